// ### hdl/gpio_edge_event_logic.sv
// register file, event flags, interrupt and table logic for four i/o
`timescale 1ns/1ps
module gpio_edge_event_logic #(
  parameter int io_count = gpio_edge_pkg::num_io
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire gpio_edge_pkg::reg_req_t req,
  output logic [7:0] rdata,
  input wire logic [io_count-1:0] io_in,
  output logic [io_count-1:0] io_logic_out,
  output logic [io_count-1:0] io_logic_oe,
  output logic irq_out_n
);
  logic [7:0] edge_sense_config;
  logic [7:0] interrupt_source_flags;
  logic [7:0] event_status_flags;
  logic [7:0] table_logic_mode;
  logic [7:0] logic_truth_table_0;
  logic [7:0] irq_mask;
  logic [io_count-1:0] level;
  logic [io_count-1:0] hit;
  logic [io_count-1:0] sense_changed;
  logic [io_count-1:0] clr_event;
  logic [io_count-1:0] clr_source;
  logic wr_sense;
  logic wr_source;
  logic wr_event;

  assign wr_sense = req.write && req.addr == gpio_edge_pkg::addr_sense_low;
  assign wr_source = req.write && req.addr == gpio_edge_pkg::addr_irq_source;
  assign wr_event = req.write && req.addr == gpio_edge_pkg::addr_event_status;

  genvar g;
  generate
    for (g = 0; g < io_count; g++) begin : g_io
      edge_detect_cell u_cell (
        .sys_clk(sys_clk),
        .reset(reset),
        .pin_in(io_in[g]),
        .sense(edge_sense_config[2*g+1:2*g]),
        .level(level[g]),
        .hit(hit[g])
      );
      assign sense_changed[g] = wr_sense && (req.wdata[2*g+1:2*g] != edge_sense_config[2*g+1:2*g]);
      assign clr_source[g] = (wr_source && req.wdata[g]) || (wr_event && req.wdata[g]) || sense_changed[g];
      assign clr_event[g] = clr_source[g];
    end
  endgenerate

  // configuration registers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      edge_sense_config <= gpio_edge_pkg::reset_value;
      table_logic_mode <= gpio_edge_pkg::reset_value;
      logic_truth_table_0 <= gpio_edge_pkg::reset_value;
      irq_mask <= gpio_edge_pkg::reset_value;
    end else if (req.write) begin
      if (req.addr == gpio_edge_pkg::addr_sense_low) edge_sense_config <= req.wdata;
      if (req.addr == gpio_edge_pkg::addr_logic_mode) table_logic_mode <= req.wdata;
      if (req.addr == gpio_edge_pkg::addr_truth_table) logic_truth_table_0 <= req.wdata;
      if (req.addr == gpio_edge_pkg::addr_irq_mask) irq_mask <= req.wdata;
    end
  end

  // event flags: a new edge wins over a clear in the same cycle, except when that cycle's write changes the pin's sense
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      event_status_flags <= gpio_edge_pkg::reset_value;
    end else begin
      for (int i = 0; i < io_count; i++) begin
        if (hit[i] && !sense_changed[i]) event_status_flags[i] <= 1'b1;
        else if (clr_event[i]) event_status_flags[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      interrupt_source_flags <= gpio_edge_pkg::reset_value;
    end else begin
      for (int i = 0; i < io_count; i++) begin
        if (hit[i] && !sense_changed[i] && !irq_mask[i]) interrupt_source_flags[i] <= 1'b1;
        else if (clr_source[i]) interrupt_source_flags[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) irq_out_n <= 1'b1;
    else irq_out_n <= ~|interrupt_source_flags;
  end

  // logic mode: pin 3 from pins 2:0, pin 2 from pins 1:0 through the truth table
  logic [io_count-1:0] next_logic_out;
  always_comb begin
    next_logic_out = '0;
    next_logic_out[3] = logic_truth_table_0[level[2:0]];
    next_logic_out[2] = logic_truth_table_0[{1'b0, level[1:0]}];
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      io_logic_out <= '0;
      io_logic_oe <= '0;
    end else begin
      io_logic_out <= next_logic_out;
      io_logic_oe <= {table_logic_mode[3], table_logic_mode[2], 2'b00};
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) rdata <= 8'h00;
    else if (req.read) begin
      unique case (req.addr)
        gpio_edge_pkg::addr_sense_low: rdata <= edge_sense_config;
        gpio_edge_pkg::addr_irq_source: rdata <= interrupt_source_flags;
        gpio_edge_pkg::addr_event_status: rdata <= event_status_flags;
        gpio_edge_pkg::addr_logic_mode: rdata <= table_logic_mode;
        gpio_edge_pkg::addr_truth_table: rdata <= logic_truth_table_0;
        gpio_edge_pkg::addr_irq_mask: rdata <= irq_mask;
        default: rdata <= 8'h00;
      endcase
    end
  end

  sense_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    (wr_sense && req.wdata[1:0] != edge_sense_config[1:0]) |=> !event_status_flags[0] && !interrupt_source_flags[0])
    else $error("sense change did not clear flags");
  source_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    (wr_source && req.wdata[0] && !hit[0]) |=> !event_status_flags[0] && !interrupt_source_flags[0])
    else $error("source write did not clear both");
  event_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    (wr_event && req.wdata[1] && !hit[1]) |=> !interrupt_source_flags[1] && !event_status_flags[1])
    else $error("event write did not clear both");
  event_set_a: assert property (@(posedge sys_clk) disable iff (reset)
    (hit[0] && !sense_changed[0]) |=> event_status_flags[0])
    else $error("edge not flagged");
  source_set_a: assert property (@(posedge sys_clk) disable iff (reset)
    (hit[2] && !sense_changed[2] && !irq_mask[2]) |=> interrupt_source_flags[2])
    else $error("unmasked edge not sourced");
  irq_level_a: assert property (@(posedge sys_clk) disable iff (reset)
    (|interrupt_source_flags) |=> !irq_out_n)
    else $error("interrupt not asserted");
  irq_release_a: assert property (@(posedge sys_clk) disable iff (reset)
    !(|interrupt_source_flags) |=> irq_out_n)
    else $error("interrupt not released");
  none_sense_a: assert property (@(posedge sys_clk) disable iff (reset)
    (edge_sense_config[1:0] == gpio_edge_pkg::sense_none) |-> !hit[0])
    else $error("disabled pin detected edge");
  fall_sense_a: assert property (@(posedge sys_clk) disable iff (reset)
    (edge_sense_config[3:2] == gpio_edge_pkg::sense_fall && hit[1]) |-> $fell(level[1]))
    else $error("falling mode misfired");
endmodule : gpio_edge_event_logic

// ### hdl/gpio_edge_pkg.sv
// package with register map, field layout and carrier types for the gpio edge event logic
package gpio_edge_pkg;
  localparam int num_io = 4;
  localparam logic [7:0] addr_sense_low = 8'h07;
  localparam logic [7:0] addr_irq_source = 8'h08;
  localparam logic [7:0] addr_event_status = 8'h09;
  localparam logic [7:0] addr_logic_mode = 8'h10;
  localparam logic [7:0] addr_truth_table = 8'h11;
  localparam logic [7:0] addr_irq_mask = 8'h12;
  localparam logic [7:0] reset_value = 8'h00;
  localparam logic [1:0] sense_none = 2'h0;
  localparam logic [1:0] sense_rise = 2'h1;
  localparam logic [1:0] sense_fall = 2'h2;
  localparam logic [1:0] sense_both = 2'h3;
  localparam int logic_mode_pos = 2;
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage : gpio_edge_pkg

// ### hdl/edge_detect_cell.sv
// one pin's synchroniser and edge classifier
`timescale 1ns/1ps
module edge_detect_cell (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic pin_in,
  input wire logic [1:0] sense,
  output logic level,
  output logic hit
);
  logic meta;
  logic prev;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      meta <= 1'b0;
      level <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin_in;
      level <= meta;
      prev <= level;
    end
  end
  always_comb begin
    unique case (sense)
      gpio_edge_pkg::sense_none: hit = 1'b0;
      gpio_edge_pkg::sense_rise: hit = level & ~prev;
      gpio_edge_pkg::sense_fall: hit = ~level & prev;
      gpio_edge_pkg::sense_both: hit = level ^ prev;
    endcase
  end
endmodule : edge_detect_cell

// ### tb/pin_model.sv
// pin side model: bench levels, replaced by the table output where the device drives a pin
`timescale 1ns/1ps
module pin_model (
  input wire logic [gpio_edge_pkg::num_io-1:0] drive,
  input wire logic [gpio_edge_pkg::num_io-1:0] oe,
  input wire logic [gpio_edge_pkg::num_io-1:0] out,
  output logic [gpio_edge_pkg::num_io-1:0] pins
);
  assign pins = (oe & out) | (~oe & drive);
endmodule : pin_model

// ### tb/testbench.sv
// self-checking bench for the gpio edge event logic
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 0;
  logic reset = 1;
  gpio_edge_pkg::reg_req_t req = '0;
  logic [7:0] rdata;
  logic [3:0] drive = 4'h0;
  logic [3:0] io_in, io_logic_out, io_logic_oe;
  logic irq_out_n;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] map [5] = '{8'h07, 8'h08, 8'h09, 8'h10, 8'h20};
  gpio_edge_event_logic i_gpio_edge_event_logic (.sys_clk(sys_clk), .reset(reset), .req(req), .rdata(rdata),
    .io_in(io_in), .io_logic_out(io_logic_out), .io_logic_oe(io_logic_oe), .irq_out_n(irq_out_n));
  pin_model i_pin_model (.drive(drive), .oe(io_logic_oe), .out(io_logic_out), .pins(io_in));
  initial forever #25 sys_clk = ~sys_clk;
  task conclude;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk) req <= '0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk) req <= '0;
    @(negedge sys_clk) chk($sformatf("reg %h", a), exp, rdata);
  endtask : rd
  task pins(input logic [3:0] v);
    @(posedge sys_clk) drive <= v;
    repeat (6) @(posedge sys_clk);
    // look at registered pin outputs away from the launching edge
    @(negedge sys_clk);
  endtask : pins
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 5000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 0;
    foreach (map[i]) rd(map[i], 8'h00);
    wr(8'h07, 8'h39);
    rd(8'h07, 8'h39);
    pins(4'h7);
    rd(8'h09, 8'h05);
    rd(8'h08, 8'h05);
    chk("irq", 8'h00, {7'h0, irq_out_n});
    pins(4'h8);
    rd(8'h09, 8'h07);
    wr(8'h08, 8'h00);
    rd(8'h09, 8'h07);
    wr(8'h08, 8'h01);
    rd(8'h08, 8'h06);
    rd(8'h09, 8'h06);
    wr(8'h09, 8'h02);
    rd(8'h08, 8'h04);
    rd(8'h09, 8'h04);
    wr(8'h07, 8'h09);
    rd(8'h09, 8'h00);
    rd(8'h08, 8'h00);
    chk("irq", 8'h01, {7'h0, irq_out_n});
    wr(8'h12, 8'h01);
    pins(4'h1);
    rd(8'h09, 8'h01);
    rd(8'h08, 8'h00);
    chk("irq", 8'h01, {7'h0, irq_out_n});
    wr(8'h11, 8'h80);
    wr(8'h10, 8'h08);
    rd(8'h10, 8'h08);
    pins(4'h7);
    chk("logic", 8'h88, {io_logic_oe[3], 3'h0, io_logic_out[3], 3'h0});
    pins(4'h3);
    chk("logic", 8'h80, {io_logic_oe[3], 3'h0, io_logic_out[3], 3'h0});
    // pin 2 from pins 1:0, table entry 3 set
    wr(8'h11, 8'h08);
    wr(8'h10, 8'h04);
    pins(4'h3);
    chk("logic2", 8'h44, {1'b0, io_logic_oe[2], 2'h0, 1'b0, io_logic_out[2], 2'h0});
    chk("logic3oe", 8'h00, {7'h0, io_logic_oe[3]});
    pins(4'h1);
    chk("logic2", 8'h40, {1'b0, io_logic_oe[2], 2'h0, 1'b0, io_logic_out[2], 2'h0});
    conclude();
  end
endmodule : testbench
